// file: cpu_model.sv
// supervised processor: kick toggling and the external latch flop
module cpu_model (
	// clock
	input wire clk,
	// control and watchdog outputs
	input wire kick_en,
	input wire pulse_n,
	input wire fault_n,
	// to the supervisor and the bench
	output logic kick,
	output logic latch_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_q = 8'h00;
	logic en_q = 1'b0;
	initial kick = 1'b0;
	initial latch_n = 1'b1;
	// one last toggle on stop, so the bench knows when the period starts
	always @(posedge clk) begin
		en_q <= kick_en;
		cnt_q <= (kick_en && cnt_q != 8'h63) ? cnt_q + 8'h01 : 8'h00;
		if ((kick_en && cnt_q == 8'h63) || (en_q && !kick_en))
			kick <= ~kick;
	end
	always @(negedge pulse_n) latch_n <= fault_n;
endmodule

// file: down_timer.v
// loadable down counter; done is high while the count is zero
module down_timer #(
	parameter W = 32
) (
	// clock and reset
	input wire clk,
	input wire reset,
	// control
	input wire load,
	input wire [W-1:0] load_val,
	input wire run,
	// status
	output wire done
);
	reg [W-1:0] cnt_q;

	always @(posedge clk) begin
		if (reset)
			cnt_q <= {W{1'b0}};
		else if (load)
			cnt_q <= load_val;
		else if (run && cnt_q != {W{1'b0}})
			cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
	end

	assign done = (cnt_q == {W{1'b0}});
endmodule

// file: sup_checker.sv
// port checker for the supervisor block
module sup_checker #(
	parameter PULSE_CYC = 50
) (
	// clock and reset
	input wire clk,
	input wire reset,
	// inputs
	input wire supply_ok,
	input wire manual_reset_n,
	input wire battery_on,
	input wire watchdog_kick_in,
	input wire kick_float,
	input wire timeout_select_in,
	input wire [7:0] cap_nf,
	// outputs
	input wire reset_out_n,
	input wire watchdog_fault_out_n,
	input wire watchdog_pulse_out_n,
	input wire ce_force_high,
	input wire kick_bias_en
);
	timeunit 1ns;
	timeprecision 1ps;
	wire r = reset_out_n;
	wire f = watchdog_fault_out_n;
	wire p = watchdog_pulse_out_n;
	logic [31:0] low_q;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// length of the current low pulse, checked when it ends
	always_ff @(posedge clk) low_q <= p ? 32'h0 : low_q + 32'h1;
	fault_in_reset_a: assert property (!r && $past(!r) |-> f)
		else $error("fault low during reset");
	pulse_in_reset_a: assert property (!r && $past(!r) |-> p)
		else $error("pulse low during reset");
	float_off_a: assert property (kick_float [*5] |-> f && p)
		else $error("watchdog active while kick floats");
	low_supply_a: assert property (!supply_ok [*5] |-> !r && !kick_bias_en)
		else $error("low supply not handled");
	manual_hold_a: assert property (!manual_reset_n [*8] ##1 !manual_reset_n [*4]
		|-> !r && ce_force_high)
		else $error("manual reset not held");
	fault_lag_a: assert property ($fell(f) |-> !$past(p, 7) && $past(p, 8))
		else $error("fault lag wrong");
	pulse_width_a: assert property ($rose(p) |-> low_q == PULSE_CYC)
		else $error("pulse width wrong");
	stretch_a: assert property ($rose(r) |-> $past(supply_ok && manual_reset_n, 200))
		else $error("reset released early");
	cover property ($fell(p));
	cover property ($fell(r) && supply_ok);
	cover property (kick_float && !f ##5 f);
endmodule

bind supervisor_reset_watchdog sup_checker #(.PULSE_CYC(PULSE_CYC)) chk (.clk(clk),
	.reset(reset), .supply_ok(supply_ok), .manual_reset_n(manual_reset_n),
	.battery_on(battery_on), .watchdog_kick_in(watchdog_kick_in), .kick_float(kick_float),
	.timeout_select_in(timeout_select_in), .cap_nf(cap_nf), .reset_out_n(reset_out_n),
	.watchdog_fault_out_n(watchdog_fault_out_n), .ce_force_high(ce_force_high),
	.watchdog_pulse_out_n(watchdog_pulse_out_n), .kick_bias_en(kick_bias_en));

// file: supervisor_defs.vh
// timing constants and figures for the supervisor and watchdog
`ifndef SUPERVISOR_DEFS_VH
`define SUPERVISOR_DEFS_VH

`define CLK_PERIOD_NS 10
// manual reset propagation delay, ns (typical)
`define MR_DELAY_NS 7000
`define MR_DELAY_CYC ((`MR_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// least manual reset pulse for full clear, ns
`define MR_PULSE_NS 25000
`define MR_PULSE_CYC ((`MR_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// reset stretch, ms
`define STRETCH_MS 200
`define STRETCH_CYC (`STRETCH_MS * 100000)
// default watchdog timeout, ms
`define WD_DEFAULT_MS 1600
`define WD_DEFAULT_CYC (`WD_DEFAULT_MS * 100000)
// capacitor timeout, microseconds per nF
`define WD_US_PER_NF 2100
`define WD_CYC_PER_NF (`WD_US_PER_NF * 100)
`define CAP_MIN_NF 8'h05
`define CAP_MAX_NF 8'h64
// least kick level duration, ns
`define KICK_MIN_NS 100
`define KICK_MIN_CYC ((`KICK_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// pulse output low time, ms
`define PULSE_MS 1
`define PULSE_CYC (`PULSE_MS * 100000)
// fault output lag behind pulse falling edge, ns
`define FAULT_LAG_NS 70
`define FAULT_LAG_CYC (`FAULT_LAG_NS / `CLK_PERIOD_NS)

`endif

// file: supervisor_reset_watchdog.v
// supervisor: reset generation with stretch, manual reset and watchdog
// Behaviour
// (RL1) reset follows manual reset low after 7us
// (RL2) 25us manual pulse clears counters, outputs high
// (RL3) qualifying manual pulse restores internal timeout
// (RL4) chip enable held high during manual reset
// (RL5) reset low while manual low, stretch after
// (RL6) reset on low supply or manual low
// (RL7) reset held 200ms after release
// (RL8) battery switchover never affects reset
// (RL9) kick stuck past timeout asserts both outputs
// (RL10) kick change of 100ns restarts timer
// (RL11) floating kick disables watchdog
// (RL12) low supply disables watchdog, kick high-z
// (RL13) fault high whenever watchdog disabled
// (RL14) fault low 70ns after pulse falls
// (RL15) pulse output low 1ms per timeout
// (RL16) external flop latches after two faults
// (RL17) tied select uses 1.6s default
// (RL18) capacitor timeout 2.1ms per nF
// (RL19) fault held high while reset asserted
// (RL20) all intervals counted on internal clock
`include "supervisor_defs.vh"

module supervisor_reset_watchdog #(
	parameter W = 32,
	parameter [W-1:0] MR_DELAY_CYC = `MR_DELAY_CYC,
	parameter [W-1:0] MR_PULSE_CYC = `MR_PULSE_CYC,
	parameter [W-1:0] STRETCH_CYC = `STRETCH_CYC,
	parameter [W-1:0] WD_DEFAULT_CYC = `WD_DEFAULT_CYC,
	parameter [W-1:0] WD_CYC_PER_NF = `WD_CYC_PER_NF,
	parameter [W-1:0] KICK_MIN_CYC = `KICK_MIN_CYC,
	parameter [W-1:0] PULSE_CYC = `PULSE_CYC,
	parameter [W-1:0] FAULT_LAG_CYC = `FAULT_LAG_CYC
) (
	// clock and reset
	input wire clk,
	input wire reset,
	// supply and manual reset comparators
	input wire supply_ok,
	input wire manual_reset_n,
	input wire battery_on,
	// three-level kick, decoded by comparators
	input wire watchdog_kick_in,
	input wire kick_float,
	// timeout select: high selects internal, else capacitor value in nF
	input wire timeout_select_in,
	input wire [7:0] cap_nf,
	// outputs
	output reg reset_out_n,
	output reg watchdog_fault_out_n,
	output reg watchdog_pulse_out_n,
	output reg ce_force_high,
	output reg kick_bias_en
);
	wire supply_s, mr_s, kick_s, float_s, sel_s;

	sync2 #(.RESET_VAL(1'b0)) u_sync_sup (.clk(clk), .reset(reset), .d(supply_ok), .q(supply_s));
	sync2 #(.RESET_VAL(1'b1)) u_sync_mr (.clk(clk), .reset(reset), .d(manual_reset_n), .q(mr_s));
	sync2 #(.RESET_VAL(1'b0)) u_sync_kick (.clk(clk), .reset(reset),
		.d(watchdog_kick_in), .q(kick_s));
	sync2 #(.RESET_VAL(1'b1)) u_sync_flt (.clk(clk), .reset(reset), .d(kick_float), .q(float_s));
	sync2 #(.RESET_VAL(1'b1)) u_sync_sel (.clk(clk), .reset(reset),
		.d(timeout_select_in), .q(sel_s));

	// the capacitor value is static, so a bitwise synchroniser cannot tear it
	wire [7:0] cap_s;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_cap_sync
			sync2 #(.RESET_VAL(1'b0)) u_sync_cap (
				.clk(clk),
				.reset(reset),
				.d(cap_nf[gi]),
				.q(cap_s[gi])
			);
		end
	endgenerate

	// battery_on is deliberately unused: switchover must not touch reset (see RL8)

	// manual reset: low time counter, delayed assertion and qualified pulse
	reg [W-1:0] mr_low_q;
	reg mr_asserted_q;
	reg mr_clear_q;
	always @(posedge clk) begin
		if (reset) begin
			mr_low_q <= {W{1'b0}};
			mr_asserted_q <= 1'b0;
			mr_clear_q <= 1'b0;
		end else if (mr_s) begin
			mr_low_q <= {W{1'b0}};
			mr_asserted_q <= 1'b0;
			mr_clear_q <= 1'b0;
		end else begin
			if (mr_low_q != {W{1'b1}})
				mr_low_q <= mr_low_q + {{(W-1){1'b0}}, 1'b1};
			if (mr_low_q + {{(W-1){1'b0}}, 1'b1} >= MR_DELAY_CYC)
				mr_asserted_q <= 1'b1; // see RL1
			if (mr_low_q + {{(W-1){1'b0}}, 1'b1} >= MR_PULSE_CYC)
				mr_clear_q <= 1'b1; // see RL2
		end
	end

	// select latched to internal after a qualifying manual pulse
	reg force_internal_q;
	always @(posedge clk) begin
		if (reset)
			force_internal_q <= 1'b0;
		else if (mr_clear_q)
			force_internal_q <= 1'b1; // see RL3
	end

	// reset source and stretch
	wire hold_reset = !supply_s || mr_asserted_q || !mr_s; // see RL5 RL6
	wire stretch_done;
	down_timer #(.W(W)) u_stretch (
		.clk(clk),
		.reset(reset),
		.load(hold_reset),
		.load_val(STRETCH_CYC), // see RL7 RL20
		.run(1'b1),
		.done(stretch_done)
	);
	reg in_reset_q;
	always @(posedge clk) begin
		if (reset)
			in_reset_q <= 1'b1;
		else if (!supply_s || mr_asserted_q)
			in_reset_q <= 1'b1; // see RL1 RL6
		else if (!hold_reset)
			in_reset_q <= !stretch_done; // see RL7
	end

	// kick qualification: new level must stand the least duration
	reg kick_stable_q;
	reg [W-1:0] kick_cnt_q;
	reg kick_event_q;
	always @(posedge clk) begin
		if (reset) begin
			kick_stable_q <= 1'b0;
			kick_cnt_q <= {W{1'b0}};
			kick_event_q <= 1'b0;
		end else begin
			kick_event_q <= 1'b0;
			// a level shorter than the least duration never leaves the count
			if (mr_clear_q) begin
				kick_stable_q <= kick_s; // see RL2
				kick_cnt_q <= {W{1'b0}};
			end else if (float_s || kick_s == kick_stable_q) begin
				kick_cnt_q <= {W{1'b0}};
			end else if (kick_cnt_q + {{(W-1){1'b0}}, 1'b1} >= KICK_MIN_CYC) begin
				kick_stable_q <= kick_s; // see RL10
				kick_cnt_q <= {W{1'b0}};
				kick_event_q <= 1'b1;
			end else begin
				kick_cnt_q <= kick_cnt_q + {{(W-1){1'b0}}, 1'b1};
			end
		end
	end

	// watchdog enable and timeout period
	wire wd_enable = supply_s && !float_s && !in_reset_q; // see RL11 RL12 RL19
	wire use_internal = sel_s || force_internal_q; // see RL3 RL17
	// capacitor values outside the valid span are clamped to its ends
	reg [7:0] cap_clip;
	always @* begin
		if (cap_s < `CAP_MIN_NF)
			cap_clip = `CAP_MIN_NF; // see RL18
		else if (cap_s > `CAP_MAX_NF)
			cap_clip = `CAP_MAX_NF;
		else
			cap_clip = cap_s;
	end
	wire [W-1:0] cap_period = WD_CYC_PER_NF * {{(W-8){1'b0}}, cap_clip}; // see RL18
	wire [W-1:0] period = use_internal ? WD_DEFAULT_CYC : cap_period; // see RL17

	localparam ST_WATCH = 2'd0;
	localparam ST_LAG = 2'd1;
	localparam ST_PULSE = 2'd2;
	localparam ST_FAULT = 2'd3;
	reg [1:0] st_q, st_d;
	reg [W-1:0] tmr_q, tmr_d;
	reg pulse_d, fault_d;

	// a kick that lands while the pulse is low is kept for the fault state;
	// dropping it would leave the fault low until one more transition
	reg kick_pend_q;
	always @(posedge clk) begin
		if (reset)
			kick_pend_q <= 1'b0;
		else if (!wd_enable || mr_clear_q || st_q == ST_WATCH || st_q == ST_FAULT)
			kick_pend_q <= 1'b0;
		else if (kick_event_q)
			kick_pend_q <= 1'b1; // see RL14
	end
	wire kick_seen = kick_event_q || kick_pend_q;

	// sequencer: count down, lag, pulse low, then hold the fault

	always @* begin
		st_d = st_q;
		tmr_d = tmr_q;
		pulse_d = 1'b1;
		fault_d = 1'b1;
		if (!wd_enable || mr_clear_q) begin
			st_d = ST_WATCH; // see RL2 RL13
			tmr_d = period;
		end else begin
			case (st_q)
			ST_WATCH: begin
				if (kick_event_q) begin
					tmr_d = period;
				end else if (tmr_q <= {{(W-1){1'b0}}, 1'b1}) begin
					st_d = ST_LAG; // see RL9
					tmr_d = FAULT_LAG_CYC;
					pulse_d = 1'b0; // see RL15
				end else begin
					tmr_d = tmr_q - {{(W-1){1'b0}}, 1'b1};
				end
			end
			ST_LAG: begin
				pulse_d = 1'b0;
				// a repeat pulse keeps the fault low through the lag
				fault_d = watchdog_fault_out_n; // see RL14
				if (tmr_q <= {{(W-1){1'b0}}, 1'b1}) begin
					st_d = ST_PULSE;
					fault_d = 1'b0; // see RL14
					tmr_d = PULSE_CYC - FAULT_LAG_CYC; // see RL15
				end else begin
					tmr_d = tmr_q - {{(W-1){1'b0}}, 1'b1};
				end
			end
			ST_PULSE: begin
				fault_d = 1'b0;
				pulse_d = 1'b0;
				if (tmr_q <= {{(W-1){1'b0}}, 1'b1}) begin
					st_d = ST_FAULT;
					pulse_d = 1'b1; // see RL15
					tmr_d = period;
				end else begin
					tmr_d = tmr_q - {{(W-1){1'b0}}, 1'b1};
				end
			end
			ST_FAULT: begin
				// fault stays until a kick; timer keeps running so a second pulse follows
				fault_d = 1'b0; // see RL14
				if (kick_seen) begin
					st_d = ST_WATCH;
					fault_d = 1'b1;
					tmr_d = period;
				end else if (tmr_q <= {{(W-1){1'b0}}, 1'b1}) begin
					st_d = ST_LAG;
					tmr_d = FAULT_LAG_CYC;
					pulse_d = 1'b0; // see RL9 RL16
				end else begin
					tmr_d = tmr_q - {{(W-1){1'b0}}, 1'b1};
				end
			end
			default: begin
				st_d = ST_WATCH;
				tmr_d = period;
			end
			endcase
		end
	end

	// watchdog state
	always @(posedge clk) begin
		if (reset) begin
			st_q <= ST_WATCH;
			tmr_q <= WD_DEFAULT_CYC;
		end else begin
			st_q <= st_d;
			tmr_q <= tmr_d;
		end
	end

	// watchdog pins
	always @(posedge clk) begin
		if (reset) begin
			watchdog_fault_out_n <= 1'b1;
			watchdog_pulse_out_n <= 1'b1;
		end else begin
			watchdog_fault_out_n <= fault_d;
			watchdog_pulse_out_n <= pulse_d;
		end
	end

	// reset pin and chip enable gate
	always @(posedge clk) begin
		if (reset) begin
			reset_out_n <= 1'b0;
			ce_force_high <= 1'b1;
		end else begin
			reset_out_n <= !in_reset_q;
			ce_force_high <= in_reset_q || !mr_s; // see RL4
		end
	end

	// kick bias follows the supply: the pin floats while the supply is low
	always @(posedge clk) begin
		if (reset)
			kick_bias_en <= 1'b0;
		else
			kick_bias_en <= supply_s; // see RL12
	end
endmodule

// file: supervisor_reset_watchdog_tb.sv
// bench for the supervisor: reset, watchdog and timeout select
module supervisor_reset_watchdog_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, reset = 1, supply_ok = 1, manual_reset_n = 1, battery_on = 0;
	logic kick_float = 0, timeout_select_in = 1, kick_en = 1;
	logic [7:0] cap_nf = 8'h0a;
	wire kick, rst_n, fault_n, pulse_n, ce_hi, bias_en, latch_n;
	int n_fail = 0, samples_checked = 0, n, pulses = 0;
	initial forever #5 clk = ~clk;
	always @(negedge pulse_n) pulses++;
	supervisor_reset_watchdog #(.STRETCH_CYC(200), .WD_DEFAULT_CYC(500), .WD_CYC_PER_NF(20),
		.PULSE_CYC(50), .MR_DELAY_CYC(5)) uut (.clk(clk), .reset(reset),
		.supply_ok(supply_ok), .manual_reset_n(manual_reset_n), .battery_on(battery_on),
		.watchdog_kick_in(kick), .kick_float(kick_float), .cap_nf(cap_nf),
		.timeout_select_in(timeout_select_in), .reset_out_n(rst_n), .ce_force_high(ce_hi),
		.watchdog_fault_out_n(fault_n), .watchdog_pulse_out_n(pulse_n),
		.kick_bias_en(bias_en));
	cpu_model cpu (.clk(clk), .kick_en(kick_en), .pulse_n(pulse_n), .fault_n(fault_n),
		.kick(kick), .latch_n(latch_n));
	task automatic complete_run;
		if (n_fail == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic c, input string m);
		samples_checked++;
		if (c !== 1'b1) begin
			n_fail++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	// cycles until the pulse output falls
	task automatic wait_pulse(output int c);
		c = 0;
		while (pulse_n !== 1'b0 && c < 2000) begin
			@(negedge clk);
			c++;
		end
	endtask
	task automatic t_power;
		cyc(190);
		chk(rst_n === 1'b0, "reset released early");
		cyc(30);
		chk(rst_n === 1'b1 && bias_en === 1'b1, "reset not released");
	endtask
	task automatic t_kicked;
		@(posedge clk) battery_on <= 1'b1;
		cyc(1500);
		chk(pulses == 0 && rst_n === 1'b1 && fault_n === 1'b1, "kicks not seen");
	endtask
	task automatic t_timeout;
		@(posedge clk) kick_en <= 1'b0;
		wait_pulse(n);
		chk(n >= 500 && n <= 520, "default timeout wrong");
		cyc(9);
		chk(fault_n === 1'b0, "fault not low");
		cyc(60);
		wait_pulse(n);
		cyc(9);
		chk(latch_n === 1'b0, "second fault not latched");
		@(posedge clk) kick_en <= 1'b1;
		cyc(130);
		chk(fault_n === 1'b1, "fault not cleared by kick");
	endtask
	task automatic t_float;
		@(posedge clk) kick_float <= 1'b1;
		kick_en <= 1'b0;
		cyc(1200);
		chk(pulses == 2 && fault_n === 1'b1, "floating kick not disabled");
		@(posedge clk) kick_en <= 1'b1;
		kick_float <= 1'b0;
		cyc(150);
	endtask
	task automatic t_cap_manual;
		@(posedge clk) timeout_select_in <= 1'b0;
		cap_nf <= 8'h02;
		kick_en <= 1'b0;
		wait_pulse(n);
		chk(n >= 100 && n <= 120, "capacitor value not clamped");
		@(posedge clk) cap_nf <= 8'h0a;
		cyc(60);
		wait_pulse(n);
		chk(n >= 185 && n <= 195, "capacitor timeout wrong");
		cyc(60);
		@(posedge clk) manual_reset_n <= 1'b0;
		cyc(12);
		chk(rst_n === 1'b0 && ce_hi === 1'b1, "manual reset not seen");
		cyc(2500);
		chk(fault_n === 1'b1 && pulse_n === 1'b1, "manual reset no clear");
		@(posedge clk) manual_reset_n <= 1'b1;
		cyc(190);
		chk(rst_n === 1'b0, "stretch after manual short");
		cyc(30);
		chk(rst_n === 1'b1, "stretch after manual long");
		wait_pulse(n);
		chk(n > 400 && n < 520, "internal timeout not restored");
		cyc(60);
		@(posedge clk) kick_en <= 1'b1;
		cyc(150);
	endtask
	task automatic t_supply;
		@(posedge clk) supply_ok <= 1'b0;
		cyc(6);
		chk(rst_n === 1'b0 && bias_en === 1'b0 && fault_n === 1'b1, "low supply");
		@(posedge clk) supply_ok <= 1'b1;
		cyc(220);
		chk(rst_n === 1'b1 && bias_en === 1'b1, "no recovery");
	endtask
	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		t_power();
		t_kicked();
		t_timeout();
		t_float();
		t_cap_manual();
		t_supply();
		complete_run();
	end
	initial begin
		#300000;
		n_fail++;
		$display("MISMATCH %0t run hung", $time);
		complete_run();
	end
endmodule

// file: sync2.v
// two flip-flop synchroniser for one bit
module sync2 #(
	parameter RESET_VAL = 1'b0
) (
	// clock and reset
	input wire clk,
	input wire reset,
	// data
	input wire d,
	output reg q
);
	reg meta_q;

	always @(posedge clk) begin
		if (reset) begin
			meta_q <= RESET_VAL;
			q <= RESET_VAL;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule
